// *** src/e1sa_cfg.svh ***
// e1sa constants: offsets, field positions, reset values, patterns
`ifndef E1SA_CFG_SVH
`define E1SA_CFG_SVH
`define E1SA_OFF_CTRL2      12'h000
`define E1SA_OFF_SA4SEQ     12'h004
`define E1SA_OFF_SA5SEQ     12'h008
`define E1SA_OFF_LINKCFG    12'h00c
`define E1SA_OFF_STATUS     12'h010
`define E1SA_BIT_AIS1       7
`define E1SA_BIT_AIS2       6
`define E1SA_BIT_FARSEL_HI  3
`define E1SA_BIT_FARSEL_LO  2
`define E1SA_BIT_COMB       1
`define E1SA_BIT_LOCCRC     0
`define E1SA_CTRL2_WMASK    8'hcf
`define E1SA_BIT_SA4EN      0
`define E1SA_BIT_SA4SEL     1
`define E1SA_BIT_SA5EN      2
`define E1SA_BIT_SA5SEL     3
`define E1SA_LINKCFG_WMASK  8'h0f
`define E1SA_RST_CTRL2      8'h00
`define E1SA_RST_SEQ        8'hff
`define E1SA_RST_LINKCFG    8'h00
`define E1SA_FAR_01         2'h1
`define E1SA_FAR_10         2'h2
`define E1SA_FAR_11         2'h3
`define E1SA_SA6_AIS        4'hf
`define E1SA_SA6_FAR01      4'h0
`define E1SA_SA6_FAR10      4'h0
`define E1SA_SA6_FAR11      4'h1
`define E1SA_SA6_CRC        4'h2
`define E1SA_SA6_BOTH       4'h3
`define E1SA_AXI_OKAY       2'h0
`define E1SA_AXI_SLVERR     2'h2
`endif

// *** src/e1sa_pkg.sv ***
// e1sa types: response codes and line-side carriers
`default_nettype none
package e1sa_pkg;
   typedef enum logic [2:0] {
      R_NONE  = 3'b000,
      R_AIS1  = 3'b001,
      R_AIS2  = 3'b010,
      R_FAR01 = 3'b011,
      R_FAR10 = 3'b100,
      R_FAR11 = 3'b101,
      R_CRC   = 3'b110,
      R_BOTH  = 3'b111
   } e1sa_resp_e;
   // receive-side conditions
   typedef struct packed {
      logic e_valid;
      logic e_bit;
      logic crc_err;
      logic ais;
   } e1sa_rx_s;
   // spare bits for the frame now being sent
   typedef struct packed {
      logic a;
      logic e;
      logic sa4;
      logic sa5;
      logic sa6;
      logic auto_on;
      logic sa4_reg_src;
      logic sa5_reg_src;
   } e1sa_spare_s;
endpackage
`default_nettype wire

// *** src/e1sa_top.sv ***
// e1sa_top: E1 transmit spare-bit auto response and Sa4/Sa5 insertion
`timescale 1ns/1ps
`default_nettype none
`include "e1sa_cfg.svh"

// Overview of operation
// - far-error select in control bits 3:2, reset zero, disables far-error response except the combined one.
// - a received E bit of zero is a far end block error.
// - select 01 on far error sends A=0, Sa5=1, Sa6=0000, E=0.
// - select 10 on far error sends A=0, Sa5=0, Sa6=0000, E=0.
// - select 11 on far error sends A=0, Sa5=1, Sa6=0001, E=1.
// - CRC response enabled, local CRC error sends A=0, Sa5=1, Sa6=0010, E=1.
// - combined enabled, far and CRC errors send A=0, Sa5=1, Sa6=0011, E=1.
// - Sa4 sequence drives Sa4 only with link enable and register source set.
// - Sa4 sequence MSB first, bit 7 in frame 2, bit 6 frame 4.
// - Sa5 sequence drives Sa5 only with link enable and register source set.
// - Sa5 sequence bit 7 in frame 2, bit 6 frame 4, onward.
// - first AIS response on AIS sends A=1, Sa5=1, Sa6 all ones.
// - second AIS response on AIS sends A=0, Sa5=1, Sa6 all ones.
module e1sa_top
   import e1sa_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // framer timing
   input  wire logic        frame_tick,
   input  wire logic        mf_sync,
   // receive conditions and transmit spare bits
   input  wire e1sa_rx_s    rx_cond,
   output e1sa_spare_s      tx_spare
);

   logic [7:0]  ctrl2_reg;
   logic [7:0]  sa4_seq_reg;
   logic [7:0]  sa5_seq_reg;
   logic [7:0]  linkcfg_reg;
   logic [11:0] awaddr_reg;
   logic        aw_held_reg;
   logic [31:0] wdata_reg;
   logic        wstrb0_reg;
   logic        w_held_reg;
   logic        wr_fire;
   logic        wr_hit;
   logic [3:0]  fcnt_reg;
   logic [3:0]  fcnt_next;
   logic        far_pend_reg;
   logic        crc_pend_reg;
   logic        ais_pend_reg;
   logic        mf_edge;
   logic        far_evt;
   e1sa_resp_e  resp_reg;
   e1sa_resp_e  resp_next;
   e1sa_spare_s spare_next;

   // fixed pattern for a response: {a, sa5, sa6 nibble, e}
   function automatic logic [6:0] resp_pattern(input e1sa_resp_e r);
      unique case (r)
         R_AIS1:  resp_pattern = {1'b1, 1'b1, `E1SA_SA6_AIS,   1'b1};
         R_AIS2:  resp_pattern = {1'b0, 1'b1, `E1SA_SA6_AIS,   1'b1};
         R_FAR01: resp_pattern = {1'b0, 1'b1, `E1SA_SA6_FAR01, 1'b0};
         R_FAR10: resp_pattern = {1'b0, 1'b0, `E1SA_SA6_FAR10, 1'b0};
         R_FAR11: resp_pattern = {1'b0, 1'b1, `E1SA_SA6_FAR11, 1'b1};
         R_CRC:   resp_pattern = {1'b0, 1'b1, `E1SA_SA6_CRC,   1'b1};
         R_BOTH:  resp_pattern = {1'b0, 1'b1, `E1SA_SA6_BOTH,  1'b1};
         R_NONE:  resp_pattern = 7'h7f;
      endcase
   endfunction

   // sequence bit for a frame: bit 7 in frame 2 (count 1), bit 6 in frame 4
   function automatic logic seq_bit(input logic [7:0] s, input logic [3:0] f);
      seq_bit = s[3'd7 - f[3:1]];
   endfunction

   // ---------------- axi4-lite slave ----------------
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_hit        = (awaddr_reg == `E1SA_OFF_CTRL2) || (awaddr_reg == `E1SA_OFF_SA4SEQ) ||
                          (awaddr_reg == `E1SA_OFF_SA5SEQ) || (awaddr_reg == `E1SA_OFF_LINKCFG);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         awaddr_reg  <= {s_axi_awaddr[11:2], 2'b00};
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wdata_reg  <= 32'h0000_0000;
         wstrb0_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         wdata_reg  <= s_axi_wdata;
         wstrb0_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `E1SA_AXI_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `E1SA_AXI_OKAY : `E1SA_AXI_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register writes, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl2_reg   <= `E1SA_RST_CTRL2;
         sa4_seq_reg <= `E1SA_RST_SEQ;
         sa5_seq_reg <= `E1SA_RST_SEQ;
         linkcfg_reg <= `E1SA_RST_LINKCFG;
      end else if (wr_fire && wstrb0_reg) begin
         unique case (awaddr_reg)
            `E1SA_OFF_CTRL2:   ctrl2_reg   <= wdata_reg[7:0] & `E1SA_CTRL2_WMASK;
            `E1SA_OFF_SA4SEQ:  sa4_seq_reg <= wdata_reg[7:0];
            `E1SA_OFF_SA5SEQ:  sa5_seq_reg <= wdata_reg[7:0];
            `E1SA_OFF_LINKCFG: linkcfg_reg <= wdata_reg[7:0] & `E1SA_LINKCFG_WMASK;
            default: ;
         endcase
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `E1SA_AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `E1SA_AXI_OKAY;
         unique case ({s_axi_araddr[11:2], 2'b00})
            `E1SA_OFF_CTRL2:   s_axi_rdata <= {24'h000000, ctrl2_reg};
            `E1SA_OFF_SA4SEQ:  s_axi_rdata <= {24'h000000, sa4_seq_reg};
            `E1SA_OFF_SA5SEQ:  s_axi_rdata <= {24'h000000, sa5_seq_reg};
            `E1SA_OFF_LINKCFG: s_axi_rdata <= {24'h000000, linkcfg_reg};
            `E1SA_OFF_STATUS:  s_axi_rdata <= {24'h000000, fcnt_reg, 1'b0, resp_reg};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `E1SA_AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- multiframe position ----------------
   assign mf_edge   = frame_tick && mf_sync;
   assign fcnt_next = mf_sync ? 4'h0 : fcnt_reg + 4'h1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fcnt_reg <= 4'h0;
      end else if (frame_tick) begin
         fcnt_reg <= fcnt_next;
      end
   end

   // ---------------- condition capture ----------------
   // far error on E=0
   assign far_evt = rx_cond.e_valid && !rx_cond.e_bit;

   // events collected over one multiframe; a new event beats the boundary clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         far_pend_reg <= 1'b0;
         crc_pend_reg <= 1'b0;
         ais_pend_reg <= 1'b0;
      end else begin
         far_pend_reg <= far_evt || (far_pend_reg && !mf_edge);
         crc_pend_reg <= rx_cond.crc_err || (crc_pend_reg && !mf_edge);
         ais_pend_reg <= rx_cond.ais || (ais_pend_reg && !mf_edge);
      end
   end

   // response chosen for the coming multiframe, highest priority first
   always_comb begin
      resp_next = R_NONE;
      if (ais_pend_reg && ctrl2_reg[`E1SA_BIT_AIS1]) begin
         resp_next = R_AIS1;
      end else if (ais_pend_reg && ctrl2_reg[`E1SA_BIT_AIS2]) begin
         resp_next = R_AIS2;
      end else if (far_pend_reg && crc_pend_reg && ctrl2_reg[`E1SA_BIT_COMB]) begin
         resp_next = R_BOTH;
      end else if (far_pend_reg && ctrl2_reg[`E1SA_BIT_FARSEL_HI:`E1SA_BIT_FARSEL_LO] != 2'h0) begin
         unique case (ctrl2_reg[`E1SA_BIT_FARSEL_HI:`E1SA_BIT_FARSEL_LO])
            `E1SA_FAR_01: resp_next = R_FAR01;
            `E1SA_FAR_10: resp_next = R_FAR10;
            default:      resp_next = R_FAR11;
         endcase
      end else if (crc_pend_reg && ctrl2_reg[`E1SA_BIT_LOCCRC]) begin
         resp_next = R_CRC;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resp_reg <= R_NONE;
      end else if (mf_edge) begin
         resp_reg <= resp_next;
      end
   end

   // ---------------- spare-bit output ----------------
   always_comb begin
      logic [6:0] pat;
      e1sa_resp_e r;
      r   = mf_edge ? resp_next : resp_reg;
      pat = resp_pattern(r);
      spare_next.auto_on     = (r != R_NONE);
      spare_next.sa4_reg_src = linkcfg_reg[`E1SA_BIT_SA4EN] && linkcfg_reg[`E1SA_BIT_SA4SEL];
      spare_next.sa5_reg_src = linkcfg_reg[`E1SA_BIT_SA5EN] && linkcfg_reg[`E1SA_BIT_SA5SEL];
      spare_next.sa4 = spare_next.sa4_reg_src ? seq_bit(sa4_seq_reg, fcnt_next) : 1'b1;
      spare_next.sa5 = spare_next.sa5_reg_src ? seq_bit(sa5_seq_reg, fcnt_next) : 1'b1;
      spare_next.a   = 1'b0;
      spare_next.e   = 1'b1;
      spare_next.sa6 = 1'b1;
      if (spare_next.auto_on) begin
         spare_next.a   = pat[6];
         spare_next.sa5 = pat[5];
         spare_next.sa6 = pat[3'd4 - {1'b0, fcnt_next[2:1]}];
         spare_next.e   = pat[0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_spare <= '{a: 1'b0, e: 1'b1, sa4: 1'b1, sa5: 1'b1, sa6: 1'b1,
                       auto_on: 1'b0, sa4_reg_src: 1'b0, sa5_reg_src: 1'b0};
      end else if (frame_tick) begin
         tx_spare <= spare_next;
      end
   end

   // ---------------- assertions ----------------
   property p_far_off;
      @(posedge aclk) disable iff (!aresetn)
      mf_edge && ctrl2_reg[3:2] == 2'h0 && !ctrl2_reg[1] |=> !(resp_reg inside {R_FAR01, R_FAR10, R_FAR11, R_BOTH});
   endproperty
   a_far_off: assert property (p_far_off) else $error("far response with select zero");
   property p_far_evt;
      @(posedge aclk) disable iff (!aresetn)
      rx_cond.e_valid && !rx_cond.e_bit |=> far_pend_reg;
   endproperty
   a_far_evt: assert property (p_far_evt) else $error("far error lost");
   property p_far01;
      @(posedge aclk) disable iff (!aresetn)
      frame_tick ##1 resp_reg == R_FAR01 |-> !tx_spare.a && tx_spare.sa5 && !tx_spare.sa6 && !tx_spare.e;
   endproperty
   a_far01: assert property (p_far01) else $error("far 01 pattern wrong");
   property p_far10;
      @(posedge aclk) disable iff (!aresetn)
      frame_tick ##1 resp_reg == R_FAR10 |-> !tx_spare.a && !tx_spare.sa5 && !tx_spare.sa6 && !tx_spare.e;
   endproperty
   a_far10: assert property (p_far10) else $error("far 10 pattern wrong");
   property p_far11;
      @(posedge aclk) disable iff (!aresetn)
      frame_tick ##1 resp_reg == R_FAR11 |->
         !tx_spare.a && tx_spare.sa5 && tx_spare.e && tx_spare.sa6 == (fcnt_reg[2:1] == 2'h3);
   endproperty
   a_far11: assert property (p_far11) else $error("far 11 pattern wrong");
   property p_crc;
      @(posedge aclk) disable iff (!aresetn)
      frame_tick ##1 resp_reg == R_CRC |->
         !tx_spare.a && tx_spare.sa5 && tx_spare.e && tx_spare.sa6 == (fcnt_reg[2:1] == 2'h2);
   endproperty
   a_crc: assert property (p_crc) else $error("crc pattern wrong");
   property p_both;
      @(posedge aclk) disable iff (!aresetn)
      mf_edge && far_pend_reg && crc_pend_reg && ctrl2_reg[1] && !ais_pend_reg |=>
         resp_reg == R_BOTH && !tx_spare.a && tx_spare.sa5 && tx_spare.e && tx_spare.sa6 == fcnt_reg[2];
   endproperty
   a_both: assert property (p_both) else $error("combined pattern wrong");
   property p_sa4_src;
      @(posedge aclk) disable iff (!aresetn)
      frame_tick && !(linkcfg_reg[0] && linkcfg_reg[1]) |=> !tx_spare.sa4_reg_src && tx_spare.sa4;
   endproperty
   a_sa4_src: assert property (p_sa4_src) else $error("sa4 inserted while disabled");
   property p_sa4_order;
      @(posedge aclk) disable iff (!aresetn)
      frame_tick ##1 tx_spare.sa4_reg_src && fcnt_reg == 4'h3 |-> tx_spare.sa4 == $past(sa4_seq_reg[6]);
   endproperty
   a_sa4_order: assert property (p_sa4_order) else $error("sa4 bit order wrong");
   property p_sa5_order;
      @(posedge aclk) disable iff (!aresetn)
      frame_tick ##1 tx_spare.sa5_reg_src && !tx_spare.auto_on && fcnt_reg == 4'h1 |->
         tx_spare.sa5 == $past(sa5_seq_reg[7]);
   endproperty
   a_sa5_order: assert property (p_sa5_order) else $error("sa5 bit order wrong");
   property p_ais1;
      @(posedge aclk) disable iff (!aresetn)
      frame_tick ##1 resp_reg == R_AIS1 |-> tx_spare.a && tx_spare.sa5 && tx_spare.sa6;
   endproperty
   a_ais1: assert property (p_ais1) else $error("ais one pattern wrong");
   property p_ais2;
      @(posedge aclk) disable iff (!aresetn)
      frame_tick ##1 resp_reg == R_AIS2 |-> !tx_spare.a && tx_spare.sa5 && tx_spare.sa6;
   endproperty
   a_ais2: assert property (p_ais2) else $error("ais two pattern wrong");
   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
      !mf_edge |=> $stable(resp_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("response changed mid multiframe");

   c_far01: cover property (@(posedge aclk) disable iff (!aresetn) resp_reg == R_FAR01);
   c_both:  cover property (@(posedge aclk) disable iff (!aresetn) resp_reg == R_BOTH);
   c_ais1:  cover property (@(posedge aclk) disable iff (!aresetn) resp_reg == R_AIS1);
   c_sa4:   cover property (@(posedge aclk) disable iff (!aresetn) tx_spare.sa4_reg_src && frame_tick);

endmodule // e1sa_top
`default_nettype wire

// *** dv/e1sa_far_end.sv ***
// far-end E1 terminal model: frame timing, receive events, spare-bit capture
`timescale 1ns/1ps
`default_nettype none
module e1sa_far_end
   import e1sa_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // scenario controls
   input  wire logic        fe_req,
   input  wire logic        crc_req,
   input  wire logic        ais_req,
   // framer side
   output logic             frame_tick,
   output logic             mf_sync,
   output e1sa_rx_s         rx_cond,
   input  wire e1sa_spare_s tx_spare,
   // lanes a, e, sa4, sa5, sa6, auto over the even frames
   output logic             mf_done,
   output logic [47:0]      got
);
   logic [1:0] ph;
   logic [3:0] fcnt;
   logic       ev;

   // e bits arrive in frames 14 and 16
   assign ev = (ph == 2'h2) && (fcnt == 4'hd || fcnt == 4'hf);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph         <= 2'h0;
         fcnt       <= 4'hf;
         frame_tick <= 1'b0;
         mf_sync    <= 1'b0;
      end else begin
         ph         <= ph + 2'h1;
         frame_tick <= (ph == 2'h3);
         mf_sync    <= (ph == 2'h3) && (fcnt == 4'hf);
         if (ph == 2'h3)
            fcnt <= fcnt + 4'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_cond <= '{1'b0, 1'b1, 1'b0, 1'b0};
      end else begin
         rx_cond.e_valid <= ev;
         // zero e bit reports far error
         rx_cond.e_bit   <= ev ? !fe_req : !rx_cond.e_bit;
         rx_cond.crc_err <= crc_req && (ph == 2'h2) && (fcnt == 4'h3);
         rx_cond.ais     <= ais_req;
      end
   end

   // first even frame lands in bit 7
   always_ff @(posedge aclk) begin
      mf_done <= aresetn && (ph == 2'h1) && (fcnt == 4'hf);
      if (ph == 2'h1 && fcnt[0]) begin
         got <= {got[46:40], tx_spare.a, got[38:32], tx_spare.e, got[30:24], tx_spare.sa4,
                 got[22:16], tx_spare.sa5, got[14:8], tx_spare.sa6, got[6:0], tx_spare.auto_on};
      end
   end
endmodule // e1sa_far_end
`default_nettype wire

// *** dv/e1_sa_bit_auto_response_test.sv ***
// self-checking bench for the E1 spare-bit auto response block
`timescale 1ns/1ps
`default_nettype none
`include "e1sa_cfg.svh"
module e1_sa_bit_auto_response_test
   import e1sa_pkg::*;
;
   logic        aclk;
   logic        aresetn;
   logic [11:0] awaddr;
   logic [11:0] araddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic        frame_tick, mf_sync, mf_done, fe_req, crc_req, ais_req;
   e1sa_rx_s    rx_cond;
   e1sa_spare_s tx_spare;
   logic [47:0] got;
   int          bad_count = 0;
   int          checks = 0;
   int          cyc = 0;
   logic [3:0]  strb_use = 4'hf;

   e1sa_top u_e1sa_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .frame_tick(frame_tick), .mf_sync(mf_sync), .rx_cond(rx_cond), .tx_spare(tx_spare));

   e1sa_far_end u_e1sa_far_end (.aclk(aclk), .aresetn(aresetn), .fe_req(fe_req),
      .crc_req(crc_req), .ais_req(ais_req), .frame_tick(frame_tick), .mf_sync(mf_sync),
      .rx_cond(rx_cond), .tx_spare(tx_spare), .mf_done(mf_done), .got(got));

   initial aclk = 1'b0;
   always #4 aclk = ~aclk;

   task automatic close_out;
      if (bad_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         close_out;
      end
   end

   task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cmp_line(input logic [47:0] g, input logic [47:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   function automatic logic [47:0] lx(input logic au, a, e, input logic [7:0] s4, s5,
                                      input logic [3:0] n6);
      return {{8{a}}, {8{e}}, s4, s5, n6, n6, {8{au}}};
   endfunction

   task automatic axw(input logic [11:0] ad, input logic [31:0] d, output logic [1:0] r);
      awaddr  <= ad;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= strb_use;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axr(input logic [11:0] ad, output logic [31:0] d, output logic [1:0] r);
      araddr  <= ad;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic wait_mf(input int n);
      repeat (n) @(posedge aclk iff mf_done);
   endtask

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axr(`E1SA_OFF_CTRL2, d, r);
      cmp_reg(d, 32'h0000_0000);
      axr(`E1SA_OFF_SA4SEQ, d, r);
      cmp_reg(d, 32'h0000_00ff);
      axr(`E1SA_OFF_SA5SEQ, d, r);
      cmp_reg(d, 32'h0000_00ff);
      axw(`E1SA_OFF_CTRL2, 32'hffff_ffff, r);
      cmp_reg({30'h0, r}, {30'h0, `E1SA_AXI_OKAY});
      axr(`E1SA_OFF_CTRL2, d, r);
      cmp_reg(d, 32'h0000_00cf);
      axw(12'h100, 32'h0000_0000, r);
      cmp_reg({30'h0, r}, {30'h0, `E1SA_AXI_SLVERR});
      axr(12'h100, d, r);
      cmp_reg({30'h0, r}, {30'h0, `E1SA_AXI_SLVERR});
      cmp_reg(d, 32'h0000_0000);
      axr(`E1SA_OFF_STATUS, d, r);
      cmp_reg(d & 32'hffff_ff0f, 32'h0000_0000);
      axw(`E1SA_OFF_STATUS, 32'h0000_0000, r);
      cmp_reg({30'h0, r}, {30'h0, `E1SA_AXI_SLVERR});
      strb_use = 4'he;
      axw(`E1SA_OFF_SA4SEQ, 32'h0000_0000, r);
      strb_use = 4'hf;
      cmp_reg({30'h0, r}, {30'h0, `E1SA_AXI_OKAY});
      axr(`E1SA_OFF_SA4SEQ, d, r);
      cmp_reg(d, 32'h0000_00ff);
      axw(`E1SA_OFF_CTRL2, 32'h0000_0000, r);
   endtask

   task automatic t_seq;
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  s4, s5;
      logic [7:0]  cfg [3] = '{8'h05, 8'h0a, 8'h0f};
      axw(`E1SA_OFF_SA4SEQ, 32'h0000_00c6, r);
      axw(`E1SA_OFF_SA5SEQ, 32'h0000_001e, r);
      axr(`E1SA_OFF_SA4SEQ, d, r);
      cmp_reg(d, 32'h0000_00c6);
      foreach (cfg[i]) begin
         axw(`E1SA_OFF_LINKCFG, {24'h0, cfg[i]}, r);
         axr(`E1SA_OFF_LINKCFG, d, r);
         cmp_reg(d, {24'h0, cfg[i]});
         wait_mf(2);
         s4 = (&cfg[i][1:0]) ? 8'hc6 : 8'hff;
         s5 = (&cfg[i][3:2]) ? 8'h1e : 8'hff;
         cmp_line(got, lx(1'b0, 1'b0, 1'b1, s4, s5, 4'hf));
      end
   endtask

   task automatic t_resp;
      logic [1:0]  r;
      logic [31:0] d;
      logic [7:0]  c;
      logic [2:0]  q;
      logic        au, a, e, s5;
      logic [3:0]  n6;
      // control, far/crc/ais, auto a e sa5, sa6 nibble
      logic [18:0] tbl [9] = '{
         {8'h04, 3'b100, 4'b1001, 4'h0}, {8'h08, 3'b100, 4'b1000, 4'h0},
         {8'h0c, 3'b100, 4'b1011, 4'h1}, {8'h01, 3'b010, 4'b1011, 4'h2},
         {8'h02, 3'b110, 4'b1011, 4'h3}, {8'h80, 3'b001, 4'b1111, 4'hf},
         {8'h40, 3'b001, 4'b1011, 4'hf}, {8'h00, 3'b111, 4'b0010, 4'hf},
         {8'h04, 3'b010, 4'b0010, 4'hf}};
      // status response code expected for each row
      logic [2:0]  code [9] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h0, 3'h0};
      foreach (tbl[i]) begin
         {c, q, au, a, e, s5, n6} = tbl[i];
         axw(`E1SA_OFF_CTRL2, {24'h0, c}, r);
         wait_mf(1);
         {fe_req, crc_req, ais_req} <= q;
         wait_mf(2);
         cmp_line(got, lx(au, a, e, 8'hc6, au ? {8{s5}} : 8'h1e, au ? n6 : 4'hf));
         {fe_req, crc_req, ais_req} <= 3'b000;
         // read lands in the last frame of the responding multiframe
         axr(`E1SA_OFF_STATUS, d, r);
         cmp_reg(d, {24'h0, 4'hf, 1'b0, code[i]});
         wait_mf(2);
         cmp_line(got, lx(1'b0, 1'b0, 1'b1, 8'hc6, 8'h1e, 4'hf));
      end
   endtask

   initial begin
      aresetn = 1'b0;
      awaddr  = 12'h000;
      awvalid = 1'b0;
      wdata   = 32'h0000_0000;
      wstrb   = 4'h0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      araddr  = 12'h000;
      arvalid = 1'b0;
      rready  = 1'b0;
      fe_req  = 1'b0;
      crc_req = 1'b0;
      ais_req = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_seq;
      t_resp;
      close_out;
   end
endmodule // e1_sa_bit_auto_response_test
`default_nettype wire
